// File: inc/panel_cfg_pkg.sv
// Shared constants and carrier types for the display configuration block.
package panel_cfg_pkg;

    localparam logic [31:0] DISPLAY_CONFIG_OFFSET = 32'h1305_0000;
    localparam logic [31:0] DISPLAY_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] DISPLAY_CONFIG_WMASK = 32'hdfff_ffff;
    localparam logic [31:0] DISPLAY_CONFIG_ADDR_MASK = 32'h0000_fffc;

    localparam int PIN_SELECT_BIT = 31;
    localparam int PAL_HALF_LINE_BIT = 30;
    localparam int LONG_DESC_BIT = 28;
    localparam int PALETTE_BYPASS_BIT = 27;
    localparam int TV_TARGET_BIT = 26;
    localparam int RECOVER_BIT = 25;
    localparam int DITHER_BIT = 24;
    localparam int GATE_N_HI = 23;
    localparam int GATE_N_LO = 20;
    localparam int HSYNC_POL_CTL_N_BIT = 19;
    localparam int DOT_CLK_POL_CTL_N_BIT = 18;
    localparam int DATA_INVERT_BIT = 17;
    localparam int SYNC_DIR_BIT = 16;
    localparam int IDLE_HI = 15;
    localparam int IDLE_LO = 12;
    localparam int HSYNC_POL_BIT = 11;
    localparam int PCLK_EDGE_BIT = 10;
    localparam int DE_POL_BIT = 9;
    localparam int VSYNC_POL_BIT = 8;
    localparam int TFT18_BIT = 7;
    localparam int TFT24_BIT = 6;
    localparam int STN_WIDTH_HI = 5;
    localparam int STN_WIDTH_LO = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 0;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        MODE_TFT_GENERIC = 4'b0000,
        MODE_TFT_SPECIAL1 = 4'b0001,
        MODE_TFT_SPECIAL2 = 4'b0010,
        MODE_TFT_SPECIAL3 = 4'b0011,
        MODE_TV_PROGRESSIVE = 4'b0100,
        MODE_RSVD5 = 4'b0101,
        MODE_TV_INTERLACED = 4'b0110,
        MODE_RSVD7 = 4'b0111,
        MODE_STN_SINGLE_COLOR = 4'b1000,
        MODE_STN_SINGLE_MONO = 4'b1001,
        MODE_STN_DUAL_COLOR = 4'b1010,
        MODE_STN_DUAL_MONO = 4'b1011,
        MODE_SERIAL_TFT8 = 4'b1100,
        MODE_LCM = 4'b1101,
        MODE_RSVDE = 4'b1110,
        MODE_RSVDF = 4'b1111
    } out_mode_type;

    // Raw timing-generator levels fed into the pin stage, all active high.
    typedef struct packed {
        logic pclk;
        logic vsync;
        logic hsync;
        logic de;
        logic strobe_a;
        logic line_clock;
        logic start_pulse;
        logic flip;
        logic [17:0] data;
        logic smart_clk;
        logic smart_cs;
        logic smart_rs;
        logic [17:0] smart_data;
    } raw_pins_type;

    // Decoded configuration shared between the register file and the pin stage.
    typedef struct packed {
        logic pin_select;
        logic tv_pal_extra_half_line;
        logic long_descriptor_select;
        logic palette_bypass;
        logic tv_target_select;
        logic underrun_recover;
        logic dither_enable;
        logic [3:0] gate_n;
        logic hsync_polarity_ctl_n;
        logic dot_clock_polarity_ctl_n;
        logic output_data_invert;
        logic sync_direction;
        logic [3:0] idle_level;
        logic hsync_polarity;
        logic pixel_clock_edge;
        logic data_enable_polarity;
        logic vsync_polarity;
        logic tft18;
        logic tft24;
        logic [1:0] stn_data_width;
        logic [3:0] mode;
    } cfg_fields_type;

    function automatic cfg_fields_type unpack_cfg(input logic [31:0] r);
        cfg_fields_type f;
        f.pin_select = r[PIN_SELECT_BIT];
        f.tv_pal_extra_half_line = r[PAL_HALF_LINE_BIT];
        f.long_descriptor_select = r[LONG_DESC_BIT];
        f.palette_bypass = r[PALETTE_BYPASS_BIT];
        f.tv_target_select = r[TV_TARGET_BIT];
        f.underrun_recover = r[RECOVER_BIT];
        f.dither_enable = r[DITHER_BIT];
        f.gate_n = r[GATE_N_HI:GATE_N_LO];
        f.hsync_polarity_ctl_n = r[HSYNC_POL_CTL_N_BIT];
        f.dot_clock_polarity_ctl_n = r[DOT_CLK_POL_CTL_N_BIT];
        f.output_data_invert = r[DATA_INVERT_BIT];
        f.sync_direction = r[SYNC_DIR_BIT];
        f.idle_level = r[IDLE_HI:IDLE_LO];
        f.hsync_polarity = r[HSYNC_POL_BIT];
        f.pixel_clock_edge = r[PCLK_EDGE_BIT];
        f.data_enable_polarity = r[DE_POL_BIT];
        f.vsync_polarity = r[VSYNC_POL_BIT];
        f.tft18 = r[TFT18_BIT];
        f.tft24 = r[TFT24_BIT];
        f.stn_data_width = r[STN_WIDTH_HI:STN_WIDTH_LO];
        f.mode = r[MODE_HI:MODE_LO];
        return f;
    endfunction : unpack_cfg

endpackage : panel_cfg_pkg

// File: verilog/sync_in3.sv
// Three-stage synchroniser with a two-stage agreement filter for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module sync_in3 #(
    parameter int WIDTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] nxt_out;

    // A bit changes only when the second and third stages agree.
    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_out = (agree & s3_ff) | (~agree & out_ff);
    assign sync_out = out_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end
endmodule : sync_in3
`default_nettype wire

// File: verilog/panel_pin_stage.sv
// Pin stage: routes, inverts, gates and polarises display pin levels.
`timescale 1ns/1ps
`default_nettype none
module panel_pin_stage
    import panel_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire cfg_fields_type cfg,
    input wire raw_pins_type raw,
    output logic [25:0] pin_out,
    output logic [25:0] pin_oe
);
    logic [25:0] nxt_pin_out;
    logic [25:0] nxt_pin_oe;
    logic [25:0] pin_out_ff;
    logic [25:0] pin_oe_ff;
    logic [3:0] special_raw;
    logic [3:0] special_lvl;
    logic hsync_lvl;
    logic vsync_lvl;
    logic de_lvl;
    logic [17:0] data_lvl;
    logic [17:0] data_mask;
    logic tft_width_sel;

    // Strobe, line clock, start pulse, flip: gate bits 23..20 and idle levels 15..12 in that order.
    assign special_raw = {raw.strobe_a, raw.line_clock, raw.start_pulse, raw.flip};
    assign special_lvl = (~cfg.gate_n & (special_raw ^ cfg.idle_level)) | (cfg.gate_n & cfg.idle_level);
    assign hsync_lvl = raw.hsync ^ (cfg.hsync_polarity & ~cfg.hsync_polarity_ctl_n);
    assign vsync_lvl = raw.vsync ^ cfg.vsync_polarity;
    assign de_lvl = raw.de ^ cfg.data_enable_polarity;
    // The 16/18 choice applies only for TFT-class modes with the 24-bit bit clear.
    assign tft_width_sel = (cfg.mode[3:2] == 2'b00) && !cfg.tft24;
    assign data_mask = (tft_width_sel && !cfg.tft18) ? 18'h0ffff : 18'h3ffff;
    assign data_lvl = (raw.data & data_mask) ^ {18{cfg.output_data_invert}};

    // Pin 25 direction belongs to the clock unit, so it is always shown as driven here outside reset.
    assign nxt_pin_out = cfg.pin_select ?
        {raw.smart_clk, raw.smart_cs, raw.smart_rs, 5'h00, raw.smart_data ^ {18{cfg.output_data_invert}}} :
        {raw.pclk ^ (cfg.pixel_clock_edge & ~cfg.dot_clock_polarity_ctl_n), vsync_lvl, hsync_lvl, de_lvl,
         special_lvl[0], special_lvl[3], special_lvl[2], special_lvl[1], data_lvl};
    assign nxt_pin_oe = cfg.pin_select ? {3'b111, 5'h00, 18'h3ffff} :
        {1'b1, ~cfg.sync_direction, ~cfg.sync_direction, 5'h1f, 18'h3ffff};

    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_ff <= 26'h0000000;
            pin_oe_ff <= 26'h0000000;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end
endmodule : panel_pin_stage
`default_nettype wire

// File: verilog/lcd_panel_config.sv
// Display configuration register with AXI4-Lite slave and decoded control outputs.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_config
    import panel_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire raw_pins_type raw_pins,
    input wire logic ext_vsync_in,
    input wire logic ext_hsync_in,
    output logic [25:0] panel_pin_out,
    output logic [25:0] panel_pin_oe,
    output logic vsync_timing,
    output logic hsync_timing,
    output logic tv_pal_extra_half_line,
    output logic long_descriptor_select,
    output logic palette_bypass,
    output logic overlay_format_bypass,
    input wire logic overlay_mode,
    output logic tv_target_select,
    output logic underrun_recover,
    output logic dither_enable,
    output logic [3:0] stn_lines,
    output logic stn_dual_split,
    output logic stn_config_bad,
    output logic [3:0] output_mode,
    output logic mode_tft,
    output logic mode_special_tft,
    output logic mode_tv,
    output logic mode_tv_interlaced,
    output logic mode_stn,
    output logic mode_serial_tft,
    output logic mode_lcm,
    output logic mode_reserved
);
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_type;

    logic [31:0] config_ff;
    logic [31:0] nxt_config;
    wr_state_type wr_state_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic wr_hit;
    logic rd_fire;
    logic rd_hit;
    logic [31:0] strb_mask;
    logic [1:0] ext_sync;
    cfg_fields_type cfg;
    out_mode_type mode_code;

    function automatic logic addr_hit(input logic [31:0] addr);
        return (addr & DISPLAY_CONFIG_ADDR_MASK) == (DISPLAY_CONFIG_OFFSET & DISPLAY_CONFIG_ADDR_MASK);
    endfunction : addr_hit

    // Write address and data may arrive in either order; each is held once taken.
    assign s_axi_awready = (wr_state_ff == WR_IDLE) && !aw_held_ff;
    assign s_axi_wready = (wr_state_ff == WR_IDLE) && !w_held_ff;
    assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_fire = (wr_state_ff == WR_IDLE) && (aw_held_ff || s_axi_awvalid) && (w_held_ff || s_axi_wvalid);
    assign wr_hit = addr_hit(wr_addr);
    assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    // Bit 29 must stay zero, so it is held out of the writable mask.
    assign nxt_config = (wr_fire && wr_hit) ?
        ((config_ff & ~(strb_mask & DISPLAY_CONFIG_WMASK)) | (wr_data & strb_mask & DISPLAY_CONFIG_WMASK)) :
        config_ff;
    assign s_axi_bvalid = (wr_state_ff == WR_RESP);
    assign s_axi_bresp = bresp_ff;

    // Reads answer one cycle after acceptance; unmapped addresses return SLVERR and zero.
    assign s_axi_arready = !rvalid_ff;
    assign rd_fire = s_axi_arvalid && !rvalid_ff;
    assign rd_hit = addr_hit(s_axi_araddr);
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_ff <= DISPLAY_CONFIG_RESET;
            wr_state_ff <= WR_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bresp_ff <= AXI_OKAY;
        end else begin
            config_ff <= nxt_config;
            unique case (wr_state_ff)
                WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_ff <= WR_RESP;
                        bresp_ff <= wr_hit ? AXI_OKAY : AXI_SLVERR;
                        aw_held_ff <= 1'b0;
                        w_held_ff <= 1'b0;
                    end else begin
                        if (s_axi_awvalid && !aw_held_ff) begin
                            aw_held_ff <= 1'b1;
                            awaddr_ff <= s_axi_awaddr;
                        end
                        if (s_axi_wvalid && !w_held_ff) begin
                            w_held_ff <= 1'b1;
                            wdata_ff <= s_axi_wdata;
                            wstrb_ff <= s_axi_wstrb;
                        end
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_ff <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_ff <= WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= AXI_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? config_ff : 32'h0000_0000;
            rresp_ff <= rd_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign cfg = unpack_cfg(config_ff);
    assign mode_code = out_mode_type'(cfg.mode);

    assign tv_pal_extra_half_line = cfg.tv_pal_extra_half_line;
    assign long_descriptor_select = cfg.long_descriptor_select | overlay_mode;
    assign palette_bypass = cfg.palette_bypass;
    assign overlay_format_bypass = cfg.palette_bypass & overlay_mode;
    // Which level means TV is not settled, so the bit is passed through raw.
    assign tv_target_select = cfg.tv_target_select;
    assign underrun_recover = cfg.underrun_recover;
    assign dither_enable = cfg.dither_enable;
    assign output_mode = cfg.mode;

    assign mode_tft = (mode_code == MODE_TFT_GENERIC);
    assign mode_special_tft = (mode_code == MODE_TFT_SPECIAL1) || (mode_code == MODE_TFT_SPECIAL2) ||
        (mode_code == MODE_TFT_SPECIAL3);
    assign mode_tv = (mode_code == MODE_TV_PROGRESSIVE) || (mode_code == MODE_TV_INTERLACED);
    assign mode_tv_interlaced = (mode_code == MODE_TV_INTERLACED);
    assign mode_stn = (cfg.mode[3:2] == 2'b10);
    assign mode_serial_tft = (mode_code == MODE_SERIAL_TFT8);
    assign mode_lcm = (mode_code == MODE_LCM);
    assign mode_reserved = (mode_code == MODE_RSVD5) || (mode_code == MODE_RSVD7) ||
        (mode_code == MODE_RSVDE) || (mode_code == MODE_RSVDF);

    // Line count per half; the dual-mono reserved widths are flagged rather than remapped.
    assign stn_lines = 4'(1 << cfg.stn_data_width);
    assign stn_dual_split = (mode_code == MODE_STN_DUAL_MONO);
    assign stn_config_bad = stn_dual_split && !cfg.stn_data_width[1];

    // External syncs are only trusted after the pin synchroniser has settled.
    sync_in3 #(
        .WIDTH(2)
    ) u_sync_in (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({ext_vsync_in, ext_hsync_in}),
        .sync_out(ext_sync)
    );

    assign vsync_timing = cfg.sync_direction ? ext_sync[1] : raw_pins.vsync;
    assign hsync_timing = cfg.sync_direction ? ext_sync[0] : raw_pins.hsync;

    panel_pin_stage u_pin_stage (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg),
        .raw(raw_pins),
        .pin_out(panel_pin_out),
        .pin_oe(panel_pin_oe)
    );
endmodule : lcd_panel_config
`default_nettype wire

// File: testbench/lcd_panel_config_assertions.sv
// Concurrent checks on the decoded outputs and pin enables of the display configuration block.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_config_assertions
    import panel_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire raw_pins_type raw_pins,
    input wire logic [25:0] panel_pin_oe,
    input wire logic vsync_timing,
    input wire logic palette_bypass,
    input wire logic overlay_format_bypass,
    input wire logic overlay_mode,
    input wire logic long_descriptor_select,
    input wire logic [3:0] stn_lines,
    input wire logic stn_dual_split,
    input wire logic [3:0] output_mode,
    input wire logic mode_tv_interlaced,
    input wire logic mode_stn,
    input wire logic mode_lcm,
    input wire logic mode_reserved
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_overlay_long_desc: assert property (overlay_mode |-> long_descriptor_select)
        else $error("overlay without long descriptor");
    a_overlay_bypass_tie: assert property (overlay_format_bypass == (palette_bypass && overlay_mode))
        else $error("overlay bypass does not follow palette bypass");
    a_stn_lines_decode: assert property ($onehot(stn_lines) && (stn_dual_split == (output_mode == 4'hb)))
        else $error("stn line count decode wrong");
    a_mode_class_decode: assert property ((mode_lcm == (output_mode == 4'hd))
        && (mode_tv_interlaced == (output_mode == 4'h6)) && (mode_stn == (output_mode[3:2] == 2'b10)))
        else $error("mode class decode wrong");
    a_mode_reserved_set: assert property (mode_reserved == (output_mode inside {4'h5, 4'h7, 4'he, 4'hf}))
        else $error("reserved mode decode wrong");
    a_pclk_dir_fixed: assert property ($past(aresetn) |-> panel_pin_oe[25])
        else $error("pixel clock pin enable dropped");
    a_sync_dir_pair: assert property (panel_pin_oe[22] |-> (panel_pin_oe[24] == panel_pin_oe[23]))
        else $error("sync pin enables differ");
    a_sync_internal_path: assert property (panel_pin_oe[24] && panel_pin_oe[22]
        |-> $past(vsync_timing) == $past(raw_pins.vsync))
        else $error("internal vsync not used while driving");
    a_smart_pins_off: assert property ($past(aresetn) |-> (panel_pin_oe[22:18] inside {5'h00, 5'h1f}))
        else $error("control pin enables split");

    c_overlay: cover property (overlay_mode && overlay_format_bypass);
    c_ext_sync: cover property (!panel_pin_oe[24] && panel_pin_oe[22]);
    c_smart: cover property (panel_pin_oe[22:18] == 5'h00 && $past(aresetn));
    c_reserved: cover property (mode_reserved);
endmodule : lcd_panel_config_assertions

bind lcd_panel_config lcd_panel_config_assertions u_checker (.aclk(aclk), .aresetn(aresetn),
    .raw_pins(raw_pins), .panel_pin_oe(panel_pin_oe), .vsync_timing(vsync_timing),
    .palette_bypass(palette_bypass), .overlay_format_bypass(overlay_format_bypass),
    .overlay_mode(overlay_mode), .long_descriptor_select(long_descriptor_select),
    .stn_lines(stn_lines), .stn_dual_split(stn_dual_split), .output_mode(output_mode),
    .mode_tv_interlaced(mode_tv_interlaced), .mode_stn(mode_stn), .mode_lcm(mode_lcm),
    .mode_reserved(mode_reserved));
`default_nettype wire

// File: testbench/panel_sync_source.sv
// External display device model that supplies the sync pins when the controller releases them.
`timescale 1ns/1ps
`default_nettype none
module panel_sync_source (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] sync_oe,
    output logic ext_vsync,
    output logic ext_hsync
);
    logic [5:0] cnt_ff;

    always_ff @(posedge aclk) begin
        cnt_ff <= aresetn ? cnt_ff + 6'h01 : 6'h00;
    end

    // Released pins carry real sync; driven pins see a toggling pattern so stale values never match.
    assign ext_vsync = (sync_oe == 2'b00) ? cnt_ff[5] : cnt_ff[0];
    assign ext_hsync = (sync_oe == 2'b00) ? cnt_ff[4] : ~cnt_ff[0];
endmodule : panel_sync_source
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the display configuration block over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import panel_cfg_pkg::*;
;
    logic aclk, aresetn, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic ar_valid, ar_ready, r_valid, r_ready, ext_vs, ext_hs, vs_t, hs_t, overlay;
    logic [31:0] aw_addr, w_data, ar_addr, r_data;
    logic [3:0] w_strb, stn_lines, out_mode;
    logic [1:0] b_resp, r_resp, lane_resp;
    logic [25:0] pin_out, pin_oe;
    logic tv_half, long_desc, pal_bp, ovl_bp, tv_sel, recover, dither, stn_split, stn_bad;
    logic m_tft, m_spec, m_tv, m_tvi, m_stn, m_ser, m_lcm, m_rsv;
    logic [3:0] m;
    logic [31:0] w;
    raw_pins_type raw;
    int miscompares, total_checks;

    lcd_panel_config u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
        .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
        .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .raw_pins(raw), .ext_vsync_in(ext_vs), .ext_hsync_in(ext_hs),
        .panel_pin_out(pin_out), .panel_pin_oe(pin_oe), .vsync_timing(vs_t), .hsync_timing(hs_t),
        .tv_pal_extra_half_line(tv_half), .long_descriptor_select(long_desc), .palette_bypass(pal_bp),
        .overlay_format_bypass(ovl_bp), .overlay_mode(overlay), .tv_target_select(tv_sel),
        .underrun_recover(recover), .dither_enable(dither), .stn_lines(stn_lines), .stn_dual_split(stn_split),
        .stn_config_bad(stn_bad), .output_mode(out_mode), .mode_tft(m_tft), .mode_special_tft(m_spec),
        .mode_tv(m_tv), .mode_tv_interlaced(m_tvi), .mode_stn(m_stn), .mode_serial_tft(m_ser),
        .mode_lcm(m_lcm), .mode_reserved(m_rsv));

    panel_sync_source u_partner (.aclk(aclk), .aresetn(aresetn), .sync_oe(pin_oe[24:23]),
        .ext_vsync(ext_vs), .ext_hsync(ext_hs));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] resp);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= d;
        w_strb <= s;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        b_t = 1'b0;
        for (int n = 0; n < 64 && !b_t; n++) begin
            @(negedge aclk);
            aw_t = aw_valid && aw_ready;
            w_t = w_valid && w_ready;
            b_t = b_valid && b_ready;
            resp = b_resp;
            @(posedge aclk);
            if (aw_t) aw_valid <= 1'b0;
            if (w_t) w_valid <= 1'b0;
        end
        b_ready <= 1'b0;
        check("write handshake", 32'h1, {31'b0, b_t});
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_t, r_t;
        @(posedge aclk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        r_t = 1'b0;
        for (int n = 0; n < 64 && !r_t; n++) begin
            @(negedge aclk);
            ar_t = ar_valid && ar_ready;
            r_t = r_valid && r_ready;
            d = r_data;
            resp = r_resp;
            @(posedge aclk);
            if (ar_t) ar_valid <= 1'b0;
        end
        r_ready <= 1'b0;
        check("read handshake", 32'h1, {31'b0, r_t});
    endtask : axi_read

    task automatic wr(input logic [31:0] d, input logic [31:0] a = DISPLAY_CONFIG_OFFSET,
        input logic [1:0] er = 2'b00);
        logic [1:0] resp;
        axi_write(a, d, 4'hf, resp);
        check("write resp", {30'b0, er}, {30'b0, resp});
    endtask : wr

    task automatic rd_chk(input string name, input logic [31:0] exp, input logic [31:0] a = DISPLAY_CONFIG_OFFSET,
        input logic [1:0] er = 2'b00);
        logic [31:0] d;
        logic [1:0] resp;
        axi_read(a, d, resp);
        check(name, exp, d);
        check("read resp", {30'b0, er}, {30'b0, resp});
    endtask : rd_chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Generous bound: the sequence needs only a few hundred cycles.
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        {aw_valid, w_valid, b_ready, ar_valid, r_ready, overlay} = 6'h00;
        {aw_addr, w_data, ar_addr, w_strb} = 100'h0;
        raw = '0;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("reset value", DISPLAY_CONFIG_RESET);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            w = 32'h1 << i;
            wr(w);
            rd_chk("walking bit", w & 32'hdfff_ffff);
            check("decoded bits", {26'b0, w[30], w[28:24]},
                {26'b0, tv_half, long_desc, pal_bp, tv_sel, recover, dither});
        end
        $display("test walking done");
        wr(32'h0);
        axi_write(DISPLAY_CONFIG_OFFSET, 32'ha5a5_a5a5, 4'b0010, lane_resp);
        check("byte lane resp", 32'h0, {30'b0, lane_resp});
        rd_chk("byte lane", 32'h0000_a500);
        wr(32'h1234_5678);
        wr(32'hffff_ffff, 32'h4, AXI_SLVERR);
        rd_chk("unmapped read", 32'h0, 32'h4, AXI_SLVERR);
        rd_chk("unmapped write kept", 32'h1234_5678);
        $display("test access done");
        overlay <= 1'b1;
        wr(32'h0800_0000);
        check("overlay decode", 32'h3, {30'b0, long_desc, ovl_bp});
        overlay <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            m = i[3:0];
            wr({28'h0, m});
            check("mode decode", {22'b0, m, m inside {4'h5, 4'h7, 4'he, 4'hf}, m inside {4'h4, 4'h6}, m == 4'hd,
                m == 4'h0, m inside {4'h1, 4'h2, 4'h3}, m == 4'hc},
                {22'b0, out_mode, m_rsv, m_tv, m_lcm, m_tft, m_spec, m_ser});
        end
        for (int i = 0; i < 4; i++) begin
            wr({26'h0, i[1:0], 4'hb});
            check("stn width", {26'b0, 4'h1 << i, 1'b1, i < 2}, {26'b0, stn_lines, stn_split, stn_bad});
        end
        $display("test decode done");
        raw.data <= 18'h15555;
        raw.hsync <= 1'b1;
        raw.de <= 1'b1;
        raw.line_clock <= 1'b1;
        wr(32'h0002_0e80);
        repeat (3) @(negedge aclk);
        check("pins inverted", {8'b1000_0010, 18'h2aaaa}, pin_out);
        wr(32'h00fc_ad00);
        repeat (3) @(negedge aclk);
        check("pins gated", {8'b0111_0101, 18'h05555}, pin_out);
        $display("test pins done");
        wr(32'h0001_0000);
        repeat (3) @(negedge aclk);
        check("sync enables", 32'h0, {30'b0, pin_oe[24:23]});
        for (int n = 0; n < 200 && ext_vs !== 1'b0; n++) @(posedge aclk);
        for (int n = 0; n < 200 && ext_vs !== 1'b1; n++) @(posedge aclk);
        repeat (8) @(negedge aclk);
        check("external sync", {30'b0, ext_vs, ext_hs}, {30'b0, vs_t, hs_t});
        raw.smart_clk <= 1'b1;
        wr(32'h8000_0000);
        repeat (3) @(negedge aclk);
        check("smart pins", {24'b0, 1'b1, 1'b1, 6'h00}, {24'b0, pin_out[25], pin_oe[25], 1'b0, pin_oe[22:18]});
        $display("test sync and smart done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
